// ---- rtl/ubr_core.sv ----
// Operation
// - Select clear: divider reads return reload value.
// - Receiver off: select gates counter interrupts.
// - Receiver off, select set: interrupt at zero.
// - Receiver off, select set: reads show count.
// - Receiver on: select only changes readback.
// - Suppress clear: data and errors interrupt.
// - Suppress set: only errors and timer interrupt.
// - Codec enabled: serial data through infrared.
// - Codec disabled: plain serial pins used.
// - Node address register, eight bits, resets zero.
// - Upper policy bit: compare every address byte.
// - Compare mode: events only from matching address onward.
// - Policy 10: match address and following data.
// - Policy 11: only data after matched address.
//
// Design decision made here: the APB register port.
`timescale 1ns/10ps
module ubr_core (
  // Clock, reset and freeze.
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clkEn,
  // APB slave.
  input wire logic [15:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Receive and transmit datapath.
  input wire ubr_pkg::ubr_rx_evt_t rxEvt,
  input wire logic txRaw,
  output logic rxSerial,
  output logic rxEnable,
  output logic mpBitTx,
  output logic drvEnLow,
  // Serial pins.
  input wire logic rxPin,
  output logic txPin,
  // Status and interrupt.
  output logic rxDataAvail,
  output logic irq
);

  logic [7:0] ctlZero_r, ctlZero_nxt;
  logic [7:0] ctlOne_r, ctlOne_nxt;
  logic [7:0] node_r, node_nxt;
  logic [7:0] brh_r, brh_nxt;
  logic [7:0] brl_r, brl_nxt;
  logic [7:0] rxData_r, rxData_nxt;
  logic [2:0] stat_r, stat_nxt;
  logic [2:0] mask_r, mask_nxt;
  logic rda_r, rda_nxt;
  logic load_r;
  logic [31:0] prdata_r;
  logic pready_r, pslverr_r;
  logic rxMeta_r, rxSync_r;
  logic txPin_r, rxSerial_r, irq_r;
  ubr_pkg::ubr_node_t nodeSt_r, nodeSt_nxt;

  wire setup = psel && !penable;
  wire access = psel && penable && pready_r;
  wire wrEn = access && pwrite;
  wire rdAcc = access && !pwrite;

  // Address decode.
  wire hitCtl0 = paddr == ubr_pkg::ADR_CTL0;
  wire hitCtl1 = paddr == ubr_pkg::ADR_CTL1;
  wire hitNode = paddr == ubr_pkg::ADR_NODE;
  wire hitBrh = paddr == ubr_pkg::ADR_BRH;
  wire hitBrl = paddr == ubr_pkg::ADR_BRL;
  wire hitRxd = paddr == ubr_pkg::ADR_RXD;
  wire hitStat = paddr == ubr_pkg::ADR_STAT;
  wire hitMask = paddr == ubr_pkg::ADR_MASK;
  wire hitAny = hitCtl0 || hitCtl1 || hitNode || hitBrh || hitBrl ||
    hitRxd || hitStat || hitMask;

  // Control fields.
  wire rxEn = ctlZero_r[ubr_pkg::B_RXEN];
  wire mpEn = ctlOne_r[ubr_pkg::B_MPEN];
  wire brgSel = ctlOne_r[ubr_pkg::B_BAUD_COUNT_SELECT];
  wire rdaSupp = ctlOne_r[ubr_pkg::B_RX_DATA_IRQ_SUPPRESS];
  wire infrared_codec_enable = ctlOne_r[ubr_pkg::B_INFRARED_CODEC_ENABLE];
  wire [1:0] mpBits = {ctlOne_r[ubr_pkg::B_MPMD1],
    ctlOne_r[ubr_pkg::B_MPMD0]};
  wire ubr_pkg::ubr_mp_t policy = ubr_pkg::ubr_mp_t'(mpBits);

  // Baud divider and its readback.
  wire baudTick;
  wire [15:0] baudCount;
  wire [15:0] brVal = brgSel ?
    baudCount : {brh_r, brl_r};

  ubr_baud_counter u_baud (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .clkEn(clkEn),
    .load(load_r),
    .reload({brh_r, brl_r}),
    .tick(baudTick),
    .count(baudCount)
  );

  // Infrared codec, fed from the synchronised pin.
  wire irTx;
  wire irRxData;

  ubr_ir_codec u_ir (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .clkEn(clkEn),
    .tick(baudTick),
    .txData(txRaw),
    .rxData(irRxData),
    .irRx(rxSync_r),
    .irTx(irTx)
  );

  // Read data selection.
  wire [31:0] rdMux =
    hitCtl0 ? {24'h00_0000, ctlZero_r} :
    hitCtl1 ? {24'h00_0000, ctlOne_r} :
    hitNode ? {24'h00_0000, node_r} :
    hitBrh ? {24'h00_0000, brVal[15:8]} :
    hitBrl ? {24'h00_0000, brVal[7:0]} :
    hitRxd ? {23'h00_0000, rda_r, rxData_r} :
    hitStat ? {29'h0000_0000, stat_r} :
    hitMask ? {29'h0000_0000, mask_r} : 32'h0000_0000;

  // Character classification; without multiprocessor mode every
  // error-free character counts as data.
  wire goodChar = rxEvt.valid && !rxEvt.err;
  wire addrByte = goodChar && mpEn && rxEvt.isAddr;
  wire dataByte = goodChar && !(mpEn && rxEvt.isAddr);
  wire addrHit = rxEvt.data == node_r;
  wire selected = nodeSt_r == ubr_pkg::NODE_SEL;

  // Acceptance by multiprocessor policy.
  wire acceptMp =
    (policy == ubr_pkg::MP_ALL) ? goodChar :
    (policy == ubr_pkg::MP_ADDR) ? addrByte :
    (policy == ubr_pkg::MP_MATCH_RUN) ?
      ((addrByte && addrHit) || (dataByte && selected)) :
    (dataByte && selected);
  wire accept = mpEn ? acceptMp : goodChar;

  // Interrupt events.
  wire dataEvt = accept && !rdaSupp;
  wire errEvt = rxEvt.valid && rxEvt.err;
  wire tmrEvt = baudTick && !rxEn && brgSel;
  wire [2:0] statSet = {tmrEvt, errEvt, dataEvt};
  wire [2:0] statClr = (wrEn && hitStat) ? pwdata[2:0] : 3'h0;

  // Next values of the software registers.
  assign ctlZero_nxt = (wrEn && hitCtl0) ? pwdata[7:0] : ctlZero_r;
  assign ctlOne_nxt = (wrEn && hitCtl1) ? pwdata[7:0] : ctlOne_r;
  assign node_nxt = (wrEn && hitNode) ? pwdata[7:0] : node_r;
  assign brh_nxt = (wrEn && hitBrh) ? pwdata[7:0] : brh_r;
  assign brl_nxt = (wrEn && hitBrl) ? pwdata[7:0] : brl_r;
  assign mask_nxt = (wrEn && hitMask) ? pwdata[2:0] : mask_r;
  assign rxData_nxt = accept ? rxEvt.data : rxData_r;
  // Setting wins over clearing for both sticky flags.
  assign stat_nxt = (stat_r & ~statClr) | statSet;
  assign rda_nxt = accept || (rda_r && !(rdAcc && hitRxd));

  // Node selection follows each compared address byte.
  always_comb begin
    nodeSt_nxt = nodeSt_r;
    case (nodeSt_r)
      ubr_pkg::NODE_IDLE: begin
        if (addrByte && addrHit) nodeSt_nxt = ubr_pkg::NODE_SEL;
      end
      ubr_pkg::NODE_SEL: begin
        if (addrByte && !addrHit) nodeSt_nxt = ubr_pkg::NODE_IDLE;
      end
      default: begin
        nodeSt_nxt = ubr_pkg::NODE_IDLE;
      end
    endcase
  end

  // Software-visible registers.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctlZero_r <= ubr_pkg::RST_CTL0;
      ctlOne_r <= ubr_pkg::RST_CTL1;
      node_r <= ubr_pkg::RST_NODE;
      brh_r <= ubr_pkg::RST_BRH;
      brl_r <= ubr_pkg::RST_BRL;
      mask_r <= ubr_pkg::RST_MASK;
    end else if (clkEn) begin
      ctlZero_r <= ctlZero_nxt;
      ctlOne_r <= ctlOne_nxt;
      node_r <= node_nxt;
      brh_r <= brh_nxt;
      brl_r <= brl_nxt;
      mask_r <= mask_nxt;
    end
  end

  // Receive status, sticky flags and node state.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rxData_r <= 8'h00;
      rda_r <= 1'b0;
      stat_r <= 3'h0;
      nodeSt_r <= ubr_pkg::NODE_IDLE;
      irq_r <= 1'b0;
      load_r <= 1'b0;
    end else if (clkEn) begin
      rxData_r <= rxData_nxt;
      rda_r <= rda_nxt;
      stat_r <= stat_nxt;
      nodeSt_r <= nodeSt_nxt;
      irq_r <= |(stat_nxt & mask_nxt);
      load_r <= wrEn && (hitBrh || hitBrl);
    end
  end

  // APB answer: zero wait states, data prepared in the setup cycle.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else if (clkEn) begin
      pready_r <= setup;
      pslverr_r <= setup && !hitAny;
      prdata_r <= (setup && !pwrite) ? rdMux : 32'h0000_0000;
    end
  end

  // Pin synchroniser and line selection.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rxMeta_r <= 1'b1;
      rxSync_r <= 1'b1;
      txPin_r <= 1'b1;
      rxSerial_r <= 1'b1;
    end else if (clkEn) begin
      rxMeta_r <= rxPin;
      rxSync_r <= rxMeta_r;
      txPin_r <= infrared_codec_enable ? irTx : txRaw;
      rxSerial_r <= infrared_codec_enable ? irRxData : rxSync_r;
    end
  end

  // Outputs, each straight from a flip-flop.
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign rxSerial = rxSerial_r;
  assign rxEnable = ctlZero_r[ubr_pkg::B_RXEN];
  assign mpBitTx = ctlOne_r[ubr_pkg::B_MPBT];
  assign drvEnLow = ctlOne_r[ubr_pkg::B_DEPOL];
  assign txPin = txPin_r;
  assign rxDataAvail = rda_r;
  assign irq = irq_r;

  // Read setup sequences for the divider bytes.
  sequence s_rdBrl;
    clkEn && setup && !pwrite && hitBrl;
  endsequence

  sequence s_rdBrh;
    clkEn && setup && !pwrite && hitBrh;
  endsequence

  property p_bdReload;
    @(posedge ref_clk) disable iff (!nrst)
    (s_rdBrl and (!brgSel)) |=> prdata == {24'h00_0000, brl_r};
  endproperty
  a_bdReload: assert property (p_bdReload)
    else $error("Reload value not returned.");

  property p_noTmrOff;
    @(posedge ref_clk) disable iff (!nrst)
    (clkEn && !rxEn && !brgSel && !stat_r[ubr_pkg::ST_TMR]) |=>
      !stat_r[ubr_pkg::ST_TMR];
  endproperty
  a_noTmrOff: assert property (p_noTmrOff)
    else $error("Timer flag set while disabled.");

  property p_tmrEvt;
    @(posedge ref_clk) disable iff (!nrst)
    (clkEn && baudTick && !rxEn && brgSel) |=>
      stat_r[ubr_pkg::ST_TMR] ##0 (irq == mask_r[ubr_pkg::ST_TMR] || irq);
  endproperty
  a_tmrEvt: assert property (p_tmrEvt)
    else $error("Counter zero gave no interrupt.");

  property p_bdLive;
    @(posedge ref_clk) disable iff (!nrst)
    (s_rdBrh and brgSel) |=> prdata == {24'h00_0000, $past(baudCount[15:8])};
  endproperty
  a_bdLive: assert property (p_bdLive)
    else $error("Live count not returned.");

  property p_rxEnNoTmr;
    @(posedge ref_clk) disable iff (!nrst)
    (clkEn && rxEn && !stat_r[ubr_pkg::ST_TMR]) |=>
      !stat_r[ubr_pkg::ST_TMR];
  endproperty
  a_rxEnNoTmr: assert property (p_rxEnNoTmr)
    else $error("Timer flag set with receiver on.");

  property p_dataIrq;
    @(posedge ref_clk) disable iff (!nrst)
    (clkEn && goodChar && !mpEn && !rdaSupp) |=>
      stat_r[ubr_pkg::ST_RXD] && rda_r;
  endproperty
  a_dataIrq: assert property (p_dataIrq)
    else $error("Received data raised no request.");

  property p_errIrq;
    @(posedge ref_clk) disable iff (!nrst)
    (clkEn && rxEvt.valid && rxEvt.err) |=> stat_r[ubr_pkg::ST_ERR];
  endproperty
  a_errIrq: assert property (p_errIrq)
    else $error("Receiver error raised no request.");

  property p_rdaSupp;
    @(posedge ref_clk) disable iff (!nrst)
    (clkEn && rdaSupp && !stat_r[ubr_pkg::ST_RXD]) |=>
      !stat_r[ubr_pkg::ST_RXD];
  endproperty
  a_rdaSupp: assert property (p_rdaSupp)
    else $error("Suppressed data raised a request.");

  property p_irTx;
    @(posedge ref_clk) disable iff (!nrst)
    (clkEn && infrared_codec_enable) |=> txPin == $past(irTx);
  endproperty
  a_irTx: assert property (p_irTx)
    else $error("Infrared path not on the pin.");

  property p_plainTx;
    @(posedge ref_clk) disable iff (!nrst)
    (clkEn && !infrared_codec_enable) |=> txPin == $past(txRaw) && rxSerial == $past(rxSync_r);
  endproperty
  a_plainTx: assert property (p_plainTx)
    else $error("Plain serial path broken.");

  property p_nodeWr;
    @(posedge ref_clk) disable iff (!nrst)
    (clkEn && wrEn && hitNode) |=> node_r == $past(pwdata[7:0]);
  endproperty
  a_nodeWr: assert property (p_nodeWr)
    else $error("Node address write lost.");

  property p_addrCmp;
    @(posedge ref_clk) disable iff (!nrst)
    (clkEn && addrByte) |=>
      (nodeSt_r == ubr_pkg::NODE_SEL) == $past(addrHit);
  endproperty
  a_addrCmp: assert property (p_addrCmp)
    else $error("Address compare result not kept.");

  property p_cmpGate;
    @(posedge ref_clk) disable iff (!nrst)
    (clkEn && mpEn && mpBits[1] && dataByte && !selected) |=>
      rxData_r == $past(rxData_r);
  endproperty
  a_cmpGate: assert property (p_cmpGate)
    else $error("Unselected data was taken.");

  property p_runMatch;
    @(posedge ref_clk) disable iff (!nrst)
    (clkEn && mpEn && policy == ubr_pkg::MP_MATCH_RUN && !rdaSupp &&
      ((addrByte && addrHit) || (dataByte && selected))) |=>
      stat_r[ubr_pkg::ST_RXD];
  endproperty
  a_runMatch: assert property (p_runMatch)
    else $error("Matched run raised no request.");

  property p_dataOnly;
    @(posedge ref_clk) disable iff (!nrst)
    (clkEn && mpEn && policy == ubr_pkg::MP_MATCH_DATA && addrByte &&
      !stat_r[ubr_pkg::ST_RXD]) |=> !stat_r[ubr_pkg::ST_RXD];
  endproperty
  a_dataOnly: assert property (p_dataOnly)
    else $error("Address byte raised a request.");

endmodule : ubr_core

// ---- rtl/ubr_pkg.sv ----
package ubr_pkg;

  // Bus widths.
  localparam int AW = 16;
  localparam int DW = 32;

  // Register indices; the byte address is four times the index.
  localparam logic [11:0] IDX_CTL0 = 12'hF42;
  localparam logic [11:0] IDX_CTL1 = 12'hF43;
  localparam logic [11:0] IDX_NODE = 12'hF45;
  localparam logic [11:0] IDX_BRH = 12'hF46;
  localparam logic [11:0] IDX_BRL = 12'hF47;
  localparam logic [11:0] IDX_RXD = 12'hF50;
  localparam logic [11:0] IDX_STAT = 12'hF51;
  localparam logic [11:0] IDX_MASK = 12'hF52;

  // Byte addresses on the APB.
  localparam logic [15:0] ADR_CTL0 = {2'b00, IDX_CTL0, 2'b00};
  localparam logic [15:0] ADR_CTL1 = {2'b00, IDX_CTL1, 2'b00};
  localparam logic [15:0] ADR_NODE = {2'b00, IDX_NODE, 2'b00};
  localparam logic [15:0] ADR_BRH = {2'b00, IDX_BRH, 2'b00};
  localparam logic [15:0] ADR_BRL = {2'b00, IDX_BRL, 2'b00};
  localparam logic [15:0] ADR_RXD = {2'b00, IDX_RXD, 2'b00};
  localparam logic [15:0] ADR_STAT = {2'b00, IDX_STAT, 2'b00};
  localparam logic [15:0] ADR_MASK = {2'b00, IDX_MASK, 2'b00};

  // Field positions of control zero and control one.
  localparam int B_RXEN = 0;
  localparam int B_MPMD1 = 7;
  localparam int B_MPEN = 6;
  localparam int B_MPMD0 = 5;
  localparam int B_MPBT = 4;
  localparam int B_DEPOL = 3;
  localparam int B_BAUD_COUNT_SELECT = 2;
  localparam int B_RX_DATA_IRQ_SUPPRESS = 1;
  localparam int B_INFRARED_CODEC_ENABLE = 0;

  // Status and mask bit positions.
  localparam int ST_W = 3;
  localparam int ST_RXD = 0;
  localparam int ST_ERR = 1;
  localparam int ST_TMR = 2;

  // Values after reset.
  localparam logic [7:0] RST_CTL0 = 8'h00;
  localparam logic [7:0] RST_CTL1 = 8'h00;
  localparam logic [7:0] RST_NODE = 8'h00;
  localparam logic [7:0] RST_BRH = 8'hFF;
  localparam logic [7:0] RST_BRL = 8'hFF;
  localparam logic [2:0] RST_MASK = 3'h0;

  // Infrared timing in baud ticks (16 ticks per bit).
  localparam logic [3:0] IR_PULSE = 4'h3;
  localparam logic [4:0] IR_STRETCH = 5'h10;

  // Multiprocessor interrupt policy.
  typedef enum logic [1:0] {
    MP_ALL = 2'b00,
    MP_ADDR = 2'b01,
    MP_MATCH_RUN = 2'b10,
    MP_MATCH_DATA = 2'b11
  } ubr_mp_t;

  // Node selection state.
  typedef enum logic {
    NODE_IDLE = 1'b0,
    NODE_SEL = 1'b1
  } ubr_node_t;

  // One received character from the receive datapath.
  typedef struct packed {
    logic valid;
    logic isAddr;
    logic err;
    logic [7:0] data;
  } ubr_rx_evt_t;

endpackage : ubr_pkg

// ---- rtl/ubr_baud_counter.sv ----
`timescale 1ns/10ps
module ubr_baud_counter (
  // Clock, reset and freeze.
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clkEn,
  // Reload control.
  input wire logic load,
  input wire logic [15:0] reload,
  // Count state.
  output logic tick,
  output logic [15:0] count
);

  // Down-counter that reloads on reaching zero.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      count <= {ubr_pkg::RST_BRH, ubr_pkg::RST_BRL};
      tick <= 1'b0;
    end else if (clkEn) begin
      tick <= 1'b0;
      if (load) begin
        count <= reload;
      end else if (count <= 16'h0001) begin
        count <= reload;
        tick <= 1'b1;
      end else begin
        count <= count - 16'h0001;
      end
    end
  end

  property p_reload;
    @(posedge ref_clk) disable iff (!nrst)
    (clkEn && !load && count == 16'h0001) |=>
      (tick && count == $past(reload));
  endproperty
  a_reload: assert property (p_reload)
    else $error("Counter did not reload at zero.");

endmodule : ubr_baud_counter

// ---- rtl/ubr_ir_codec.sv ----
`timescale 1ns/10ps
module ubr_ir_codec (
  // Clock, reset and freeze.
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic tick,
  // Plain serial side.
  input wire logic txData,
  output logic rxData,
  // Infrared side.
  input wire logic irRx,
  output logic irTx
);

  logic [3:0] phase_r;
  logic [4:0] hold_r;

  // A zero bit is sent as a short pulse; a received pulse is
  // stretched back into a full bit low.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      phase_r <= 4'h0;
      hold_r <= 5'h00;
      irTx <= 1'b0;
      rxData <= 1'b1;
    end else if (clkEn) begin
      if (tick) begin
        phase_r <= phase_r + 4'h1;
      end
      irTx <= !txData && (phase_r < ubr_pkg::IR_PULSE);
      if (irRx) begin
        hold_r <= ubr_pkg::IR_STRETCH;
      end else if (tick && hold_r != 5'h00) begin
        hold_r <= hold_r - 5'h01;
      end
      rxData <= !(irRx || hold_r != 5'h00);
    end
  end

endmodule : ubr_ir_codec

// ---- testbench/ubr_remote_node.sv ----
`timescale 1ns/10ps
// Far-side node: it repeats every line level that it hears after DLY cycles.
// A short delay gives a prompt echo, a long one a slow one.
module ubr_remote_node #(
  parameter int DLY = 2
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic nrst,
  // Line from the block and line back to it.
  input wire logic txLine,
  output logic rxLine
);
  logic [DLY-1:0] pipe;

  // The echo pipe idles high, like a plain serial line at rest.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pipe <= '1;
    end else begin
      pipe <= {pipe[DLY-2:0], txLine};
    end
  end

  // The oldest stage drives the line back.
  assign rxLine = pipe[DLY-1];
endmodule : ubr_remote_node

// ---- testbench/tb.sv ----
`timescale 1ns/10ps
module tb;
  // Clock, reset and bus signals.
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic clkEn = 1'b1;
  logic [15:0] paddr = 16'h0000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  ubr_pkg::ubr_rx_evt_t rxEvt = '0;
  logic txRaw = 1'b1;
  logic rxSerial, rxEnable, mpBitTx, drvEnLow, rxPin, txPin;
  logic rxDataAvail, irq;
  int nFail = 0;
  int checkCount = 0;
  int cyc = 0;
  int hi, lo;
  logic [31:0] rd, v1;
  logic err;
  logic [3:0] expMp;
  logic [7:0] pol;

  // Clock of 50 ns period.
  always #25 ref_clk = ~ref_clk;

  ubr_core ubr_core_i (.ref_clk(ref_clk), .nrst(nrst), .clkEn(clkEn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxEvt(rxEvt), .txRaw(txRaw), .rxSerial(rxSerial),
    .rxEnable(rxEnable), .mpBitTx(mpBitTx), .drvEnLow(drvEnLow),
    .rxPin(rxPin), .txPin(txPin), .rxDataAvail(rxDataAvail), .irq(irq));

  ubr_remote_node #(.DLY(2)) ubr_remote_node_i (.ref_clk(ref_clk),
    .nrst(nrst), .txLine(txPin), .rxLine(rxPin));

  // Compares one value and counts it.
  task chk(input string name, input logic [31:0] seen,
           input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      nFail++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Prints the counts and the verdict, then stops.
  task endSim;
    $display("checks %0d mismatches %0d", checkCount, nFail);
    if (nFail == 0 && checkCount > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : endSim

  // One APB transfer; the request holds until pready is seen high.
  // Only the bench timeout can cut the wait short.
  task apb(input logic wr, input logic [15:0] a, input logic [7:0] wd);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= wr;
    pwdata <= {24'h00_0000, wd};
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Reads one register and compares it.
  task rchk(input string name, input logic [15:0] a,
            input logic [31:0] exp);
    apb(1'b0, a, 8'h00);
    chk(name, rd, exp);
  endtask : rchk

  // One received character, a single-cycle valid pulse.
  task rxe(input logic isA, input logic e, input logic [7:0] d);
    @(posedge ref_clk);
    rxEvt <= {1'b1, isA, e, d};
    @(posedge ref_clk);
    rxEvt.valid <= 1'b0;
    @(posedge ref_clk);
  endtask : rxe

  // Reads the divider twice and judges whether it shows a live count.
  task live;
    apb(1'b0, ubr_pkg::ADR_BRL, 8'h00);
    v1 = rd;
    apb(1'b0, ubr_pkg::ADR_BRL, 8'h00);
    chk("live", {31'h0, (v1 <= 32'h0000_0020) && (rd !== v1)}, 32'h1);
  endtask : live

  // Cuts a hang short.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      nFail++;
      endSim();
    end
  end

  // Main sequence.
  initial begin
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    chk("pins0", {29'h0, rxEnable, mpBitTx, drvEnLow}, 32'h0);
    rchk("node", ubr_pkg::ADR_NODE, 32'h0000_0000);
    rchk("brh", ubr_pkg::ADR_BRH, 32'h0000_00FF);
    apb(1'b1, ubr_pkg::ADR_NODE, 8'h5A);
    rchk("node", ubr_pkg::ADR_NODE, 32'h0000_005A);
    apb(1'b1, 16'h3D00, 8'h12);
    chk("slverr", {31'h0, err}, 32'h1);
    // Divider as a timer with the receiver off.
    apb(1'b1, ubr_pkg::ADR_BRH, 8'h00);
    apb(1'b1, ubr_pkg::ADR_BRL, 8'h20);
    apb(1'b1, ubr_pkg::ADR_MASK, 8'h04);
    rchk("reload", ubr_pkg::ADR_BRL, 32'h0000_0020);
    apb(1'b1, ubr_pkg::ADR_CTL1, 8'h04);
    live();
    apb(1'b1, ubr_pkg::ADR_STAT, 8'h07);
    repeat (40) @(posedge ref_clk);
    chk("irq", {31'h0, irq}, 32'h1);
    rchk("tmr", ubr_pkg::ADR_STAT, 32'h0000_0004);
    apb(1'b1, ubr_pkg::ADR_STAT, 8'h07);
    repeat (40) @(posedge ref_clk);
    rchk("tmr", ubr_pkg::ADR_STAT, 32'h0000_0004);
    apb(1'b1, ubr_pkg::ADR_CTL1, 8'h00);
    apb(1'b1, ubr_pkg::ADR_STAT, 8'h07);
    repeat (40) @(posedge ref_clk);
    rchk("tmr", ubr_pkg::ADR_STAT, 32'h0000_0000);
    chk("irq", {31'h0, irq}, 32'h0);
    // Receiver on: select only moves the readback.
    apb(1'b1, ubr_pkg::ADR_CTL0, 8'h01);
    apb(1'b1, ubr_pkg::ADR_CTL1, 8'h04);
    chk("rxen", {31'h0, rxEnable}, 32'h1);
    apb(1'b1, ubr_pkg::ADR_STAT, 8'h07);
    repeat (40) @(posedge ref_clk);
    rchk("tmr", ubr_pkg::ADR_STAT, 32'h0000_0000);
    live();
    apb(1'b1, ubr_pkg::ADR_CTL1, 8'h00);
    rchk("reload", ubr_pkg::ADR_BRL, 32'h0000_0020);
    // Data and error interrupts, with and without suppression.
    apb(1'b1, ubr_pkg::ADR_MASK, 8'h03);
    rxe(1'b0, 1'b0, 8'h3C);
    chk("irq", {31'h0, irq}, 32'h1);
    rchk("rxd", ubr_pkg::ADR_RXD, 32'h0000_013C);
    apb(1'b1, ubr_pkg::ADR_STAT, 8'h07);
    rxe(1'b0, 1'b1, 8'h00);
    apb(1'b0, ubr_pkg::ADR_STAT, 8'h00);
    chk("err", rd & 32'h2, 32'h2);
    apb(1'b1, ubr_pkg::ADR_STAT, 8'h07);
    apb(1'b1, ubr_pkg::ADR_CTL1, 8'h02);
    rxe(1'b0, 1'b0, 8'h11);
    chk("irq", {31'h0, irq}, 32'h0);
    rxe(1'b0, 1'b1, 8'h00);
    chk("irq", {31'h0, irq}, 32'h1);
    // Address bytes and data under all four multiprocessor policies.
    apb(1'b1, ubr_pkg::ADR_MASK, 8'h01);
    for (int p = 0; p < 4; p++) begin
      pol = (p == 0) ? 8'hC0 : (p == 1) ? 8'hE0 : (p == 2) ? 8'h40 : 8'h60;
      expMp = (p == 0) ? 4'b0011 : (p == 1) ? 4'b0010 :
        (p == 2) ? 4'b1111 : 4'b0101;
      apb(1'b1, ubr_pkg::ADR_CTL1, pol);
      for (int k = 0; k < 4; k++) begin
        apb(1'b1, ubr_pkg::ADR_STAT, 8'h07);
        apb(1'b0, ubr_pkg::ADR_RXD, 8'h00);
        rxe(k[0] == 1'b0, 1'b0, (k == 2) ? 8'h33 : 8'h5A);
        chk("mpirq", {31'h0, irq},
            {31'h0, expMp[k]});
        chk("avail", {31'h0, rxDataAvail}, {31'h0, expMp[k]});
      end
    end
    // Plain and infrared line paths, divider at one.
    apb(1'b1, ubr_pkg::ADR_BRL, 8'h01);
    apb(1'b1, ubr_pkg::ADR_CTL1, 8'h18);
    txRaw <= 1'b0;
    repeat (12) @(posedge ref_clk);
    chk("ctlpins", {30'h0, mpBitTx, drvEnLow}, 32'h3);
    chk("txpin", {31'h0, txPin}, 32'h0);
    chk("rxser", {31'h0, rxSerial}, 32'h0);
    txRaw <= 1'b1;
    repeat (12) @(posedge ref_clk);
    apb(1'b1, ubr_pkg::ADR_CTL1, 8'h01);
    // The pin still shows the plain line for one cycle after the write.
    @(posedge ref_clk);
    hi = 0;
    repeat (48) begin
      @(posedge ref_clk);
      hi += txPin;
    end
    chk("irIdle", hi, 0);
    txRaw <= 1'b0;
    hi = 0;
    lo = 0;
    repeat (64) begin
      @(posedge ref_clk);
      hi += txPin;
      lo += !rxSerial;
    end
    txRaw <= 1'b1;
    chk("irTx", {31'h0, hi > 0 && hi < 48}, 32'h1);
    // Each echoed pulse is stretched over a whole bit, so the line
    // stays low far longer than the pulses alone would keep it.
    chk("irRx", {31'h0, lo > 32}, 32'h1);
    endSim();
  end
endmodule : tb
